//--- src/ucmft_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module ucmft_top #(
  parameter int DEPTH = ucmft_pkg::FIFO_DEPTH,
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [8:0] rx_data,
  input wire logic rx_addr_bit,
  input wire logic rx_parity_bit,
  input wire logic rx_parity_err,
  input wire logic rx_stop_ok,
  input wire logic rx_break,
  input wire logic rx_noisy,
  input wire logic tx_pop,
  output logic tx_valid,
  output logic [10:0] tx_word,
  output logic match_seen,
  output logic timers_irq_request
);
  // Elaboration checks on the parameters
  if (DEPTH != 4) begin : g_depth_chk
    $error("fifo depth must be 4");
  end
  if (TW < 2 || TW > 16) begin : g_tw_chk
    $error("timer width 2..16");
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic w_tx = wr && paddr == ucmft_pkg::OFS_TXDATA;
  wire logic w_flg = wr && paddr == ucmft_pkg::OFS_FLAGS;
  wire logic w_tm = wr && paddr == ucmft_pkg::OFS_TIMER;
  wire logic r_tm = rd && paddr == ucmft_pkg::OFS_TIMER;
  wire logic w_rcm = wr && paddr == ucmft_pkg::OFS_RXCMD;
  wire logic w_mat = wr && paddr == ucmft_pkg::OFS_MATCH;
  wire logic w_mod = wr && paddr == ucmft_pkg::OFS_MODE;
  wire logic w_ca = wr && paddr == ucmft_pkg::OFS_TCNT_A;
  wire logic w_cb = wr && paddr == ucmft_pkg::OFS_TCNT_B;
  wire logic mapped = paddr inside {ucmft_pkg::OFS_TXDATA,
    ucmft_pkg::OFS_FLAGS, ucmft_pkg::OFS_TIMER, ucmft_pkg::OFS_FIFO,
    ucmft_pkg::OFS_RXCMD, ucmft_pkg::OFS_GSTAT, ucmft_pkg::OFS_MATCH,
    ucmft_pkg::OFS_MODE, ucmft_pkg::OFS_TCNT_A, ucmft_pkg::OFS_TCNT_B,
    ucmft_pkg::OFS_RXDATA};

  logic [7:0] match_r;
  logic [4:0] mode_r;
  logic [2:0] txf_r;
  logic [1:0] gate_r;
  logic [1:0] expired_r;
  logic [TW-1:0] reload_a_r, reload_b_r, cnt_a_r, cnt_b_r;
  logic [6:0] rxf_r;
  logic [8:0] rxd_r;
  logic rx_lock_r;
  logic [10:0] txq_r [4];
  logic [1:0] txq_wp_r, txq_rp_r;
  logic [2:0] txq_cnt_r;
  logic [2:0] rxq_cnt_r;

  wire logic mdrop = mode_r[ucmft_pkg::MODE_MDROP];
  wire logic swpar = mode_r[ucmft_pkg::MODE_SWPAR];
  wire logic nine = mode_r[ucmft_pkg::MODE_NINE];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Match byte, mode bits, transmit flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_r <= 8'h00;
      mode_r <= 5'h00;
      txf_r <= 3'h0;
    end else begin
      if (w_mat) match_r <= pwdata[7:0];
      if (w_mod) mode_r <= pwdata[4:0];
      if (w_flg) txf_r <= pwdata[7:5];
    end
  end

  // ----------------------------------------
  // Transmit queue
  // ----------------------------------------
  // Entry: {multidrop, parity/flag6, ninth, data}
  wire logic tx_full = txq_cnt_r == 3'h4;
  wire logic tx_push = w_tx & ~tx_full;
  wire logic tx_take = tx_pop & tx_valid;
  wire logic tx_par_bit = swpar & txf_r[1];
  wire logic tx_d8_bit = nine & txf_r[0];
  wire logic [10:0] tx_entry = {txf_r[2], tx_par_bit, tx_d8_bit,
    pwdata[7:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txq_wp_r <= 2'h0;
      txq_rp_r <= 2'h0;
      txq_cnt_r <= 3'h0;
    end else begin
      if (tx_push) txq_wp_r <= txq_wp_r + 2'h1;
      if (tx_take) txq_rp_r <= txq_rp_r + 2'h1;
      txq_cnt_r <= txq_cnt_r + {2'h0, tx_push} - {2'h0, tx_take};
    end
  end

  // Queue storage, one entry per data write accepted while not full
  always_ff @(posedge pclk) begin
    if (tx_push) txq_r[txq_wp_r] <= tx_entry;
  end

  // Entries left after this cycle's take
  wire logic [2:0] tx_left = txq_cnt_r - {2'h0, tx_take};

  // Registered queue head, held while empty so no stale slot shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_word <= 11'h000;
    end else begin
      tx_valid <= tx_left != 3'h0;
      if (tx_left != 3'h0)
        tx_word <= tx_take ? txq_r[txq_rp_r + 2'h1] : txq_r[txq_rp_r];
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  wire logic [8:0] rx_eff = nine ? rx_data : {1'b0, rx_data[7:0]};
  wire logic cmp_ok = mdrop ? rx_addr_bit : 1'b1;
  wire logic is_match = rx_valid & cmp_ok
    & (rx_eff[7:0] == match_r);
  wire logic perr_eff = swpar ? 1'b0 : rx_parity_err;
  wire logic ferr = ~rx_stop_ok;
  logic brk_prev_r;
  wire logic brk_first = rx_break & ~brk_prev_r;
  wire logic [6:0] rxf_new = {
    ~(perr_eff | ferr),
    rx_noisy,
    swpar ? rx_parity_bit : rx_parity_err,
    rx_addr_bit & mdrop,
    rx_break,
    ferr | brk_first,
    nine & rx_data[8]};
  wire logic rx_q_in = rx_valid & ~rx_lock_r & (rxq_cnt_r != 3'h4);
  wire logic rx_q_out = rd && paddr == ucmft_pkg::OFS_RXDATA
    && rxq_cnt_r != 3'h0;

  // Flags load in step with the data; match pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_r <= ucmft_pkg::RXF_RST;
      rxd_r <= 9'h000;
      brk_prev_r <= 1'b0;
      match_seen <= 1'b0;
    end else begin
      if (rx_valid) begin
        rxf_r <= rxf_new;
        rxd_r <= rx_eff;
        brk_prev_r <= rx_break;
      end
      match_seen <= is_match & ~mdrop;
    end
  end

  // Receive lock and occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_lock_r <= 1'b0;
      rxq_cnt_r <= 3'h0;
    end else begin
      if (w_rcm && pwdata[3]) rx_lock_r <= 1'b1;
      else if (w_rcm && (pwdata[2] || pwdata[5])) rx_lock_r <= 1'b0;
      else if (mdrop && is_match) rx_lock_r <= 1'b0;
      if (w_rcm && pwdata[4]) rxq_cnt_r <= 3'h0;
      else rxq_cnt_r <= rxq_cnt_r + {2'h0, rx_q_in} - {2'h0, rx_q_out};
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  wire logic brg_a = mode_r[ucmft_pkg::MODE_BRG_A];
  wire logic brg_b = mode_r[ucmft_pkg::MODE_BRG_B];
  wire logic st_a = w_tm & pwdata[ucmft_pkg::TM_START_A] & ~brg_a;
  wire logic st_b = w_tm & pwdata[ucmft_pkg::TM_START_B] & ~brg_b;
  wire logic run_a = gate_r[0] & ~brg_a & (cnt_a_r != '0);
  wire logic run_b = gate_r[1] & ~brg_b & (cnt_b_r != '0);
  wire logic tc_a = run_a & (cnt_a_r == TW'(1));
  wire logic tc_b = run_b & (cnt_b_r == TW'(1));

  // Reload values and gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_a_r <= '0;
      reload_b_r <= '0;
      gate_r <= ucmft_pkg::GATE_RST;
    end else begin
      if (w_ca) reload_a_r <= pwdata[TW-1:0];
      if (w_cb) reload_b_r <= pwdata[TW-1:0];
      if (w_tm && !brg_a) gate_r[0] <= pwdata[ucmft_pkg::TM_GATE_A];
      if (w_tm && !brg_b) gate_r[1] <= pwdata[ucmft_pkg::TM_GATE_B];
    end
  end

  // Down counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
    end else begin
      if (st_a) cnt_a_r <= reload_a_r;
      else if (run_a) cnt_a_r <= cnt_a_r - TW'(1);
      if (st_b) cnt_b_r <= reload_b_r;
      else if (run_b) cnt_b_r <= cnt_b_r - TW'(1);
    end
  end

  // Expiry: set wins over read clear
  wire logic [1:0] expired_nxt = (r_tm ? 2'h0 : expired_r)
    | {tc_b, tc_a};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_r <= 2'h0;
      timers_irq_request <= 1'b0;
    end else begin
      expired_r <= expired_nxt;
      timers_irq_request <= |expired_nxt;
    end
  end

  // ----------------------------------------
  // Read mux and bus answer
  // ----------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (paddr)
      ucmft_pkg::OFS_FLAGS: rmux = {25'h0, rxf_r};
      ucmft_pkg::OFS_TIMER: rmux = {26'h0, gate_r, 2'h0, expired_r};
      ucmft_pkg::OFS_FIFO: rmux = {25'h0, rxq_cnt_r, 1'b0, txq_cnt_r};
      ucmft_pkg::OFS_GSTAT: rmux = {26'h0, timers_irq_request, 5'h0};
      ucmft_pkg::OFS_MATCH: rmux = {24'h0, match_r};
      ucmft_pkg::OFS_MODE: rmux = {27'h0, mode_r};
      ucmft_pkg::OFS_TCNT_A: rmux = 32'(reload_a_r);
      ucmft_pkg::OFS_TCNT_B: rmux = 32'(reload_b_r);
      ucmft_pkg::OFS_RXDATA: rmux = {23'h0, rxd_r};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // No wait state: answer in the first cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= rmux;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wire logic w_tx_done = w_tx & pready;
  sequence tx_write_s;
    w_tx_done && !tx_full;
  endsequence
  sequence tm_read_s;
    r_tm && pready && !tc_a && !tc_b;
  endsequence
  sequence rx_char_s;
    rx_valid;
  endsequence

  // Transmit queue
  tx_push_cnt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_write_s and !tx_take) |=> txq_cnt_r == $past(txq_cnt_r) + 3'h1)
    else $error("tx push lost");
  tx_par_sw_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_push |-> tx_entry[9] == (swpar & txf_r[1]))
    else $error("tx parity flag wrong");
  tx_ninth_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_push |-> tx_entry[8] == (nine & txf_r[0]))
    else $error("tx ninth bit wrong");

  // Receive flags and data
  rx_ok_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_valid && rx_stop_ok && !rx_parity_err
    |=> rxf_r[ucmft_pkg::RXF_OK])
    else $error("good flag not set");
  rx_ninth_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_valid && !nine |=> !rxf_r[ucmft_pkg::RXF_D8])
    else $error("ninth bit not zero");
  rx_noisy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s |=> rxf_r[ucmft_pkg::RXF_NOISY] == $past(rx_noisy))
    else $error("noisy flag wrong");
  rx_perr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s ##0 !swpar
    |=> rxf_r[ucmft_pkg::RXF_PERR] == $past(rx_parity_err))
    else $error("parity error flag wrong");
  rx_swpar_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s ##0 swpar
    |=> rxf_r[ucmft_pkg::RXF_PERR] == $past(rx_parity_bit))
    else $error("raw parity bit not held");
  rx_brk_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s ##0 (rx_break && !brk_prev_r) |=> rxf_r[ucmft_pkg::RXF_FERR])
    else $error("first break char without framing error");
  rx_data_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s |=> rxd_r[7:0] == $past(rx_data[7:0]))
    else $error("received data not loaded");

  // Character match
  match_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_char_s ##0 (!mdrop && rx_data[7:0] == match_r) |=> match_seen)
    else $error("match not reported");
  mdrop_data_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mdrop |=> !match_seen)
    else $error("match reported in multidrop mode");

  // Timers
  timer_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !gate_r[0] && !st_a |=> cnt_a_r == $past(cnt_a_r))
    else $error("timer a moved while gated");
  start_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_a |=> cnt_a_r == $past(reload_a_r))
    else $error("timer a not loaded by start");
  gate_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !w_tm |=> $stable(gate_r))
    else $error("gate changed without command");
  expire_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tm_read_s |=> expired_r == 2'h0 && !timers_irq_request)
    else $error("expiry not cleared by read");
  expire_src_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(expired_r[0]) |-> $past(tc_a))
    else $error("expiry a without terminal count");
  expire_b_src_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(expired_r[1]) |-> $past(tc_b))
    else $error("expiry b without terminal count");
  irq_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tc_a |=> expired_r[0] && timers_irq_request)
    else $error("timer irq not raised");
  brg_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    brg_a && w_tm |=> gate_r[0] == $past(gate_r[0]))
    else $error("gate changed in baud mode");

  // Occupancy and bus answer
  fifo_range_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    txq_cnt_r <= 3'h4 && rxq_cnt_r <= 3'h4)
    else $error("fifo count out of range");
  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
endmodule

//--- inc/ucmft_pkg.sv
package ucmft_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_TXDATA = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TIMER = 8'h0C;
  localparam logic [7:0] OFS_FIFO = 8'h10;
  localparam logic [7:0] OFS_RXCMD = 8'h14;
  localparam logic [7:0] OFS_GSTAT = 8'h18;
  localparam logic [7:0] OFS_MATCH = 8'h1C;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_TCNT_A = 8'h24;
  localparam logic [7:0] OFS_TCNT_B = 8'h28;
  localparam logic [7:0] OFS_RXDATA = 8'h2C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TXF_PAR = 6;
  localparam int TXF_D8 = 5;
  localparam int RXF_OK = 6;
  localparam int RXF_NOISY = 5;
  localparam int RXF_PERR = 4;
  localparam int RXF_ADDR = 3;
  localparam int RXF_BRK = 2;
  localparam int RXF_FERR = 1;
  localparam int RXF_D8 = 0;
  localparam int TM_GATE_A = 4;
  localparam int TM_GATE_B = 5;
  localparam int TM_START_A = 0;
  localparam int TM_START_B = 1;
  localparam int GS_TIR = 5;
  localparam int RXQ_LO = 4;
  localparam int MODE_MDROP = 0;
  localparam int MODE_SWPAR = 1;
  localparam int MODE_NINE = 2;
  localparam int MODE_BRG_A = 3;
  localparam int MODE_BRG_B = 4;
  // ----------------------------------------
  // Reset values and depths
  // ----------------------------------------
  localparam logic [1:0] GATE_RST = 2'h3;
  localparam logic [6:0] RXF_RST = 7'h40;
  localparam int FIFO_DEPTH = 4;
endpackage

//--- test/ucmft_station.sv
`timescale 1ns/10ps
module ucmft_station (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic [10:0] tx_word,
  input wire logic stall,
  output logic rx_valid,
  output logic [8:0] rx_data,
  output logic [5:0] rx_q,
  output logic tx_pop
);
  logic [10:0] got[$];
  int gap;
  // Lines idle before the first frame
  initial begin
    rx_valid = 1'b0;
    rx_data = 9'h000;
    rx_q = 6'h00;
  end
  // One character for one cycle, then lines scrambled
  task automatic send(input logic [8:0] d, input logic [5:0] q);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_q <= q;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_q <= ~q;
  endtask
  // Consumer: one pop at most every few cycles, held off by stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pop <= 1'b0;
      gap <= 0;
    end else if (tx_pop) begin
      got.push_back(tx_word);
      tx_pop <= 1'b0;
      gap <= 4;
    end else if (gap != 0) begin
      gap <= gap - 1;
    end else if (tx_valid && !stall) begin
      tx_pop <= 1'b1;
    end
  end
endmodule

//--- test/uart_char_match_flags_timers_tb_top.sv
`timescale 1ns/10ps
module uart_char_match_flags_timers_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, e;
  logic rx_valid, tx_pop, tx_valid, match_seen, irq, sw, nn, md, bp;
  logic [8:0] d, rx_data;
  logic [5:0] q, rx_q;
  logic [10:0] tx_word;
  logic [15:0] lf;
  logic [10:0] exq[$];
  int failures, tests_run, n;
  // ------
  // Design and far-side station
  // ------
  ucmft_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_addr_bit(rx_q[5]),
    .rx_parity_bit(rx_q[4]), .rx_parity_err(rx_q[3]),
    .rx_stop_ok(rx_q[2]), .rx_break(rx_q[1]), .rx_noisy(rx_q[0]),
    .tx_pop(tx_pop), .tx_valid(tx_valid), .tx_word(tx_word),
    .match_seen(match_seen), .timers_irq_request(irq));
  ucmft_station st (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_word(tx_word), .stall(stall), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_q(rx_q), .tx_pop(tx_pop));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ------
  // Helpers
  // ------
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm,
    input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rd & m);
  endtask
  task automatic wirq(input logic x);
    n = 0;
    while (irq !== x && n < 100) begin
      @(posedge pclk);
      n++;
    end
    #1 chk("irq", x, irq);
  endtask
  // Watchdog
  initial begin
    #200000;
    failures++;
    close_out();
  end
  // ------
  // Main sequence
  // ------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 1'b1;
    failures = 0;
    tests_run = 0;
    lf = 16'h0228;
    bp = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ucmft_pkg::OFS_FLAGS, 32'h40, "rx_flags");
    rdc(ucmft_pkg::OFS_TIMER, 32'h30, "timer_state");
    rdc(ucmft_pkg::OFS_FIFO, 32'h0, "fifo_occupancy");
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test reset done");
    // Received characters under all parity and width modes
    apb(1'b1, ucmft_pkg::OFS_MATCH, 32'h000000A5);
    for (int i = 0; i < 16; i++) begin
      sw = i[0];
      nn = i[1];
      md = i[2];
      apb(1'b1, ucmft_pkg::OFS_MODE, {29'h0, nn, sw, md});
      lf = nx(lf);
      d = lf[8:0];
      q = lf[15:10];
      if (i % 3 == 0) d[7:0] = 8'hA5;
      st.send(d, q);
      e = {31'h0, !md && d[7:0] == 8'hA5};
      #1 chk("match_seen", e, {31'h0, match_seen});
      e = {25'h0, q[2] && (sw || !q[3]), q[0], sw ? q[4] : q[3], q[5] & md,
        q[1], !q[2] || (q[1] && !bp), nn & d[8]};
      bp = q[1];
      rdc(ucmft_pkg::OFS_FLAGS, e, "rx_flags");
      rdc(ucmft_pkg::OFS_FIFO, 32'h10, "rx_count");
      rdc(ucmft_pkg::OFS_RXDATA, {23'h0, d[8] & nn, d[7:0]}, "rx_data");
    end
    $display("test receive done");
    // Transmit queue filled past full while the station stalls
    apb(1'b1, ucmft_pkg::OFS_MODE, 32'h6);
    for (int j = 0; j < 5; j++) begin
      lf = nx(lf);
      apb(1'b1, ucmft_pkg::OFS_FLAGS, {25'h0, lf[6:5], 5'h0});
      apb(1'b1, ucmft_pkg::OFS_TXDATA, {24'h0, lf[15:8]});
      if (j < 4) exq.push_back({1'b0, lf[6], lf[5], lf[15:8]});
    end
    rdc(ucmft_pkg::OFS_FIFO, 32'h4, "tx_count");
    stall <= 1'b0;
    n = 0;
    while (st.got.size() < 4 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("tx_words", 32'h4, st.got.size());
    foreach (exq[k]) chk("tx_word", exq[k], st.got[k]);
    rdc(ucmft_pkg::OFS_FIFO, 32'h0, "tx_count");
    $display("test transmit done");
    // Timers: expiry, read clear, gate hold, baud mode
    apb(1'b1, ucmft_pkg::OFS_MODE, 32'h0);
    apb(1'b1, ucmft_pkg::OFS_TCNT_A, 32'h5);
    apb(1'b1, ucmft_pkg::OFS_TIMER, 32'h31);
    wirq(1'b1);
    rdc(ucmft_pkg::OFS_TIMER, 32'h31, "timer_state");
    rdc(ucmft_pkg::OFS_TIMER, 32'h30, "timer_state");
    wirq(1'b0);
    apb(1'b1, ucmft_pkg::OFS_TIMER, 32'h21);
    repeat (20) @(posedge pclk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rdc(ucmft_pkg::OFS_TIMER, 32'h20, "timer_state");
    apb(1'b1, ucmft_pkg::OFS_TIMER, 32'h30);
    wirq(1'b1);
    rdc(ucmft_pkg::OFS_TIMER, 32'h31, "timer_state");
    apb(1'b1, ucmft_pkg::OFS_MODE, 32'h08);
    apb(1'b1, ucmft_pkg::OFS_TIMER, 32'h21);
    rdc(ucmft_pkg::OFS_TIMER, 32'h30, "timer_state");
    apb(1'b1, ucmft_pkg::OFS_MODE, 32'h0);
    repeat (20) @(posedge pclk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    $display("test timers done");
    close_out();
  end
endmodule
